// >>> core/fcg_regs.svh
`ifndef FCG_REGS_SVH
`define FCG_REGS_SVH
`define FCG_ADDR_CTRL      8'h40
`define FCG_ADDR_DUTY0     8'h30
`define FCG_ADDR_RANGE0    8'h5F
`define FCG_NUM_FANS       3
`define FCG_BIT_START      0
`define FCG_BIT_LOCK       1
`define FCG_BIT_READY      2
`define FCG_BIT_OVRD       3
`define FCG_BIT_THERM      4
`define FCG_BIT_SAFE       5
`define FCG_RES_HI         7
`define FCG_RES_LO         6
`define FCG_CTRL_RESET     8'h00
`define FCG_CTRL_WMASK     8'h3B
`define FCG_DUTY_FULL      8'hFF
`define FCG_RANGE_DEFAULT  8'hC3
`define FCG_RANGE_DEF_LOW  4'h3
`define FCG_READY_CYCLES   16'h0100
`endif

// >>> core/fcg_pkg.sv
package fcg_pkg;
  typedef enum logic [2:0] {
    FCG_WAIT_RESET = 3'h1,
    FCG_WAIT_ADC   = 3'h2,
    FCG_UP         = 3'h4
  } fcg_pwr_t;
endpackage

// >>> core/fcg_ready_seq.sv
`include "fcg_regs.svh"
module fcg_ready_seq
  import fcg_pkg::*;
#(
  parameter logic [15:0] WAIT_CYCLES = `FCG_READY_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic adc_ok,
  output logic      ready
);
  initial if (WAIT_CYCLES == 16'h0000) $error("WAIT_CYCLES must be nonzero");
  fcg_pwr_t    state, next_state;
  logic [15:0] cnt, next_cnt;
  // Sequence: reset settle count, then wait for converters
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      FCG_WAIT_RESET: begin
        next_cnt = cnt + 16'h0001;
        if (cnt == WAIT_CYCLES - 16'h0001) next_state = FCG_WAIT_ADC;
      end
      FCG_WAIT_ADC: if (adc_ok) next_state = FCG_UP;
      FCG_UP:       next_state = FCG_UP;
      default:      next_state = FCG_WAIT_RESET;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= FCG_WAIT_RESET;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end
  assign ready = (state == FCG_UP);
  chk_ready_after_adc: assert property (@(posedge clk) disable iff (rst)
    $rose(ready) |-> $past(adc_ok))
    else $error("ready rose without converters ok");
endmodule // fcg_ready_seq

// >>> core/fcg_fan_out.sv
`include "fcg_regs.svh"
module fcg_fan_out (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       ovrd,
  input  wire logic       safe,
  input  wire logic       manual,
  input  wire logic       disabled,
  input  wire logic       over_abs,
  input  wire logic [7:0] auto_duty,
  input  wire logic [7:0] manual_duty,
  output logic      [7:0] duty
);
  logic [7:0] next_duty;
  // Override first, even over disabled; then start gating
  always_comb begin
    if (ovrd)                          next_duty = `FCG_DUTY_FULL;
    else if (!start)                   next_duty = `FCG_DUTY_FULL;
    else if (disabled)                 next_duty = 8'h00;
    else if (manual && safe && over_abs) next_duty = `FCG_DUTY_FULL;
    else if (manual)                   next_duty = manual_duty;
    else                               next_duty = auto_duty;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) duty <= `FCG_DUTY_FULL;
    else     duty <= next_duty;
  end
endmodule // fcg_fan_out

// >>> core/fcg_ctrl.sv
`include "fcg_regs.svh"
module fcg_ctrl
  import fcg_pkg::*;
#(
  parameter int          NUM_FANS    = `FCG_NUM_FANS,
  parameter logic [15:0] READY_WAIT  = `FCG_READY_CYCLES
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  input  wire logic                  WR_EN,
  input  wire logic [7:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  output logic      [7:0]            RDATA,
  input  wire logic                  ADC_OK,
  input  wire logic [NUM_FANS-1:0]   FAN_MANUAL,
  input  wire logic [NUM_FANS-1:0]   FAN_DISABLED,
  input  wire logic                  ZONE_OVER_ABS,
  input  wire logic [NUM_FANS*8-1:0] AUTO_DUTY,
  output logic      [NUM_FANS*8-1:0] DUTY,
  output logic      [NUM_FANS*4-1:0] RANGE_FREQ,
  output logic                       PROC_THERMAL_IF_ENABLE,
  output logic                       READY
);
  initial if (NUM_FANS < 1 || NUM_FANS > 3) $error("NUM_FANS must be 1..3");

  // ADC, zone, manual and disabled pin inputs pass two flops
  logic       adc_s1, adc_s2, zone_s1, zone_s2;
  logic [NUM_FANS-1:0] man_s1, man_s2, dis_s1, dis_s2;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      adc_s1 <= 1'b0; adc_s2 <= 1'b0; zone_s1 <= 1'b0; zone_s2 <= 1'b0;
      man_s1 <= '0; man_s2 <= '0; dis_s1 <= '0; dis_s2 <= '0;
    end else begin
      adc_s1 <= ADC_OK; adc_s2 <= adc_s1;
      zone_s1 <= ZONE_OVER_ABS; zone_s2 <= zone_s1;
      man_s1 <= FAN_MANUAL; man_s2 <= man_s1;
      dis_s1 <= FAN_DISABLED; dis_s2 <= dis_s1;
    end
  end

  // Address match helper, used for each register group
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input int idx);
    hit = (a == base + idx[7:0]);
  endfunction

  // Control register state
  logic [7:0] ctrl, next_ctrl;
  logic       ready_i;
  wire        locked = ctrl[`FCG_BIT_LOCK];
  always_comb begin
    next_ctrl = ctrl;
    if (WR_EN && ADDR == `FCG_ADDR_CTRL) begin
      // Start and override always writable
      next_ctrl[`FCG_BIT_START] = WDATA[`FCG_BIT_START];
      next_ctrl[`FCG_BIT_OVRD]  = WDATA[`FCG_BIT_OVRD];
      next_ctrl[`FCG_BIT_SAFE]  = WDATA[`FCG_BIT_SAFE];
      // Lock only sets, never clears
      next_ctrl[`FCG_BIT_LOCK]  = locked | WDATA[`FCG_BIT_LOCK];
      if (!locked)
        next_ctrl[`FCG_BIT_THERM] = WDATA[`FCG_BIT_THERM];
    end
    next_ctrl[`FCG_BIT_READY] = ready_i;
    next_ctrl[`FCG_RES_HI:`FCG_RES_LO] = 2'h0;
  end
  // Only power-on reset clears this register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) ctrl <= `FCG_CTRL_RESET;
    else     ctrl <= next_ctrl;
  end

  fcg_ready_seq #(.WAIT_CYCLES(READY_WAIT)) u_ready (
    .clk    (CORE_CLK),
    .rst    (RST),
    .adc_ok (adc_s2),
    .ready  (ready_i)
  );

  // Stored parameters; range writes blocked once locked, manual duty writes gated by manual mode only
  logic [7:0] range_reg [NUM_FANS];
  logic [7:0] next_range [NUM_FANS];
  logic [7:0] man_duty [NUM_FANS];
  logic [7:0] next_man_duty [NUM_FANS];
  logic [7:0] duty_i [NUM_FANS];
  logic [NUM_FANS*4-1:0] next_rf;

  genvar g;
  generate
    for (g = 0; g < NUM_FANS; g++) begin : g_fan
      always_comb begin
        next_range[g] = range_reg[g];
        // Start bit never touches stored contents
        if (WR_EN && !locked && hit(ADDR, `FCG_ADDR_RANGE0, g))
          next_range[g] = WDATA;
        next_man_duty[g] = man_duty[g];
        if (WR_EN && man_s2[g] && hit(ADDR, `FCG_ADDR_DUTY0, g))
          next_man_duty[g] = WDATA;
        // Defaults stay until start; stored value used after
        next_rf[g*4 +: 4] = ctrl[`FCG_BIT_START] ?
                            range_reg[g][3:0] : `FCG_RANGE_DEF_LOW;
      end
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          range_reg[g] <= `FCG_RANGE_DEFAULT;
          man_duty[g]  <= `FCG_DUTY_FULL;
        end else begin
          range_reg[g] <= next_range[g];
          man_duty[g]  <= next_man_duty[g];
        end
      end
      fcg_fan_out u_out (
        .clk         (CORE_CLK),
        .rst         (RST),
        .start       (ctrl[`FCG_BIT_START]),
        .ovrd        (ctrl[`FCG_BIT_OVRD]),
        .safe        (ctrl[`FCG_BIT_SAFE]),
        .manual      (man_s2[g]),
        .disabled    (dis_s2[g]),
        .over_abs    (zone_s2),
        .auto_duty   (AUTO_DUTY[g*8 +: 8]),
        .manual_duty (man_duty[g]),
        .duty        (duty_i[g])
      );
      assign DUTY[g*8 +: 8] = duty_i[g];
      chk_locked_range_hold: assert property (@(posedge CORE_CLK)
        disable iff (RST) $past(locked) |-> $stable(range_reg[g]))
        else $error("locked range register changed");
      chk_ovrd_full_duty: assert property (@(posedge CORE_CLK)
        disable iff (RST) $past(ctrl[`FCG_BIT_OVRD])
        |-> duty_i[g] == `FCG_DUTY_FULL)
        else $error("override did not force full duty");
      chk_nostart_full: assert property (@(posedge CORE_CLK)
        disable iff (RST) $past(!ctrl[`FCG_BIT_START])
        |-> duty_i[g] == `FCG_DUTY_FULL)
        else $error("duty not full while stopped");
      // Frequency bits fall back to default whenever start is clear
      chk_range_default: assert property (@(posedge CORE_CLK)
        disable iff (RST) !ctrl[`FCG_BIT_START]
        |=> RANGE_FREQ[g*4 +: 4] == `FCG_RANGE_DEF_LOW)
        else $error("range output not default while stopped");
      // Programmed frequency bits reach the output once started
      chk_range_started: assert property (@(posedge CORE_CLK)
        disable iff (RST) ctrl[`FCG_BIT_START]
        |=> RANGE_FREQ[g*4 +: 4] == $past(range_reg[g][3:0]))
        else $error("range output ignores stored value");
      // A write aimed at a locked range register must bounce
      chk_lock_blocks_wr: assert property (@(posedge CORE_CLK)
        disable iff (RST) locked && WR_EN
        && hit(ADDR, `FCG_ADDR_RANGE0, g)
        |=> $stable(range_reg[g]))
        else $error("write landed in locked range register");
      // Control writes leave stored parameters alone
      chk_start_keeps: assert property (@(posedge CORE_CLK)
        disable iff (RST) WR_EN && ADDR == `FCG_ADDR_CTRL
        |=> $stable(range_reg[g]))
        else $error("control write altered range register");
      // Manual fan over its absolute limit with safety armed
      sequence fan_safe_trip;
        ctrl[`FCG_BIT_SAFE] && ctrl[`FCG_BIT_START] && !ctrl[`FCG_BIT_OVRD]
          && man_s2[g] && zone_s2 && !dis_s2[g];
      endsequence
      chk_safe_full: assert property (@(posedge CORE_CLK)
        disable iff (RST) fan_safe_trip
        |=> duty_i[g] == `FCG_DUTY_FULL)
        else $error("safety did not force full duty");
    end
  endgenerate

  // Registered outputs and read mux
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (ADDR == `FCG_ADDR_CTRL) next_rdata = ctrl;
    for (int i = 0; i < NUM_FANS; i++) begin
      if (hit(ADDR, `FCG_ADDR_DUTY0, i))  next_rdata = duty_i[i];
      if (hit(ADDR, `FCG_ADDR_RANGE0, i)) next_rdata = range_reg[i];
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA                  <= 8'h00;
      RANGE_FREQ             <= '0;
      PROC_THERMAL_IF_ENABLE <= 1'b0;
      READY                  <= 1'b0;
    end else begin
      RDATA                  <= next_rdata;
      RANGE_FREQ             <= next_rf;
      PROC_THERMAL_IF_ENABLE <= ctrl[`FCG_BIT_THERM];
      READY                  <= ctrl[`FCG_BIT_READY];
    end
  end

  chk_lock_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    locked |=> locked)
    else $error("lock bit cleared");
  chk_therm_frozen: assert property (@(posedge CORE_CLK) disable iff (RST)
    locked |=> $stable(ctrl[`FCG_BIT_THERM]))
    else $error("thermal enable changed while locked");
  chk_start_writable: assert property (@(posedge CORE_CLK) disable iff (RST)
    WR_EN && ADDR == `FCG_ADDR_CTRL
    |=> ctrl[`FCG_BIT_START] == $past(WDATA[`FCG_BIT_START]))
    else $error("start write lost");
  chk_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctrl[`FCG_RES_HI:`FCG_RES_LO] == 2'h0)
    else $error("reserved bits nonzero");
  // Ready never drops once the power-up sequence is done
  chk_ready_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    READY |=> READY)
    else $error("ready flag dropped");
  // Thermal interface output follows the control bit
  chk_therm_out: assert property (@(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> PROC_THERMAL_IF_ENABLE == $past(ctrl[`FCG_BIT_THERM]))
    else $error("thermal enable output lags control bit");
endmodule // fcg_ctrl

// >>> dv/fcg_ctrl_tb.sv
module fcg_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst;
  logic        wr_en;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        adc_ok;
  logic [2:0]  fan_manual;
  logic [2:0]  fan_disabled;
  logic        zone_over_abs;
  logic [23:0] auto_duty;
  logic [23:0] duty;
  logic [11:0] range_freq;
  logic        proc_en;
  logic        ready;
  logic [7:0]  rd;
  int          errors;
  int          checks_done;
  int          cycles;

  // Short ready wait keeps the power-up sequence quick
  fcg_ctrl #(.NUM_FANS(3), .READY_WAIT(16'h0004)) dut_u (
    .CORE_CLK(core_clk), .RST(rst), .WR_EN(wr_en), .ADDR(addr),
    .WDATA(wdata), .RDATA(rdata), .ADC_OK(adc_ok),
    .FAN_MANUAL(fan_manual), .FAN_DISABLED(fan_disabled),
    .ZONE_OVER_ABS(zone_over_abs), .AUTO_DUTY(auto_duty), .DUTY(duty),
    .RANGE_FREQ(range_freq), .PROC_THERMAL_IF_ENABLE(proc_en),
    .READY(ready));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // Hang guard, far above the roughly 100 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Writes change at the falling edge, strobe lasts one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask

  // Read data is registered, so sample one cycle after the address
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    addr = a;
    @(negedge core_clk);
    d = rdata;
  endtask

  // Manual, disabled and zone inputs pass two sync flops before the duty register
  task automatic settle();
    repeat (5) @(negedge core_clk);
  endtask

  task automatic t_reset_state();
    rdr(8'h40, rd);
    chk(rd, 24'h000000);
    chk(ready, 1'b0);
    chk(duty, 24'hFFFFFF);
    chk(range_freq, 12'h333);
  endtask

  task automatic t_ready();
    adc_ok = 1'b1;
    repeat (16) @(negedge core_clk);
    chk(ready, 1'b1);
    wr(8'h40, 8'hC0);
    rdr(8'h40, rd);
    chk(rd, 24'h000004);
  endtask

  // Programmed values stay idle until start, and survive start toggles
  task automatic t_start();
    wr(8'h5F, 8'h5A);
    settle();
    chk(range_freq, 12'h333);
    chk(duty, 24'hFFFFFF);
    wr(8'h40, 8'h01);
    settle();
    chk(range_freq, 12'h33A);
    chk(duty, 24'h302010);
    wr(8'h40, 8'h00);
    settle();
    chk(range_freq, 12'h333);
    chk(duty, 24'hFFFFFF);
    rdr(8'h5F, rd);
    chk(rd, 24'h00005A);
  endtask

  // Override must beat a disabled output
  task automatic t_override();
    fan_disabled = 3'h7;
    wr(8'h40, 8'h01);
    settle();
    chk(duty, 24'h000000);
    wr(8'h40, 8'h09);
    settle();
    chk(duty, 24'hFFFFFF);
    fan_disabled = 3'h0;
  endtask

  task automatic t_safety();
    fan_manual = 3'h1;
    wr(8'h40, 8'h01);
    wr(8'h30, 8'h40);
    zone_over_abs = 1'b1;
    settle();
    chk(duty, 24'h302040);
    wr(8'h40, 8'h21);
    settle();
    chk(duty, 24'h3020FF);
    zone_over_abs = 1'b0;
    fan_manual = 3'h0;
  endtask

  // Lock is one-way; start stays writable afterwards
  task automatic t_lock();
    wr(8'h40, 8'h13);
    rdr(8'h40, rd);
    chk(rd, 24'h000017);
    chk(proc_en, 1'b1);
    wr(8'h40, 8'h00);
    rdr(8'h40, rd);
    chk(rd, 24'h000016);
    chk(proc_en, 1'b1);
    wr(8'h5F, 8'h77);
    rdr(8'h5F, rd);
    chk(rd, 24'h00005A);
    wr(8'h40, 8'h01);
    settle();
    chk(range_freq, 12'h33A);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    adc_ok = 1'b0;
    fan_manual = 3'h0;
    fan_disabled = 3'h0;
    zone_over_abs = 1'b0;
    auto_duty = 24'h302010;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    t_reset_state();
    t_ready();
    t_start();
    t_override();
    t_safety();
    t_lock();
    test_done();
  end
endmodule // fcg_ctrl_tb
